// >>> core/pmc_power_mode_controller.sv
// power mode controller: idle, stop and shutdown sequencing plus reset hold
// assumes core signals instruction completion and interrupt return on clk_sys
`include "pmc_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module pmc_power_mode_controller (
  input  wire logic        clk_sys,
  input  wire logic        rstn,
  input  wire logic        idle_set,
  input  wire logic        stop_set,
  input  wire logic        regulator_off_on_stop,
  input  wire logic        instr_done,
  input  wire logic        irq_pending,
  input  wire logic        interrupt_return_instr,
  input  wire logic        ext_reset_n,
  input  wire logic        por_reset_n,
  input  wire logic        internal_reset,
  input  wire logic        supply_low,
  output logic             core_halt,
  output logic             periph_clk_en,
  output logic             osc_en,
  output logic             regulator_en,
  output logic             analog_pwr_en,
  output logic             pin_hold,
  output logic             idle_bit,
  output logic             system_reset,
  output logic             pc_reset,
  output logic [15:0]      reset_vector,
  output logic             clk_sel,
  output logic             resume_pending
);

  pmc_pkg::pmc_state_type state_q;
  logic                   idle_bit_q;
  logic                   resume_q;
  logic                   rst_q;
  logic                   req_q;
  logic                   sd_q;
  logic                   reset_req;
  logic                   wake_reset;

  //--------------------------------------------------
  // reset sources
  //--------------------------------------------------
  // shutdown is woken only by the pin reset, power-on reset or low supply
  assign wake_reset = !ext_reset_n || !por_reset_n || supply_low;
  assign reset_req  = (state_q == pmc_pkg::PMC_SHUTDOWN) ? wake_reset
                                                          : (wake_reset || internal_reset);

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
      rst_q <= 1'b1;
    else
      rst_q <= reset_req;
  end

  //--------------------------------------------------
  // mode state machine
  //--------------------------------------------------
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      state_q <= pmc_pkg::PMC_NORMAL;
      req_q   <= 1'b0;
      sd_q    <= 1'b0;
    end
    else if (reset_req)
    begin
      state_q <= pmc_pkg::PMC_NORMAL;
      req_q   <= 1'b0;
      sd_q    <= 1'b0;
    end
    else
    begin
      case (state_q)
        pmc_pkg::PMC_NORMAL:
        begin
          if (stop_set)
          begin
            req_q <= 1'b1;
            sd_q  <= regulator_off_on_stop;
          end
          if (instr_done && (stop_set || req_q))
            state_q <= (stop_set ? regulator_off_on_stop : sd_q)
                       ? pmc_pkg::PMC_SHUTDOWN : pmc_pkg::PMC_STOP;
          else if (idle_set && !stop_set && !req_q)
            state_q <= instr_done ? pmc_pkg::PMC_IDLE : pmc_pkg::PMC_IDLE_WAIT;
        end
        pmc_pkg::PMC_IDLE_WAIT:
          if (stop_set)
          begin
            req_q   <= 1'b1;
            sd_q    <= regulator_off_on_stop;
            state_q <= pmc_pkg::PMC_NORMAL;
          end
          else if (instr_done)
            state_q <= pmc_pkg::PMC_IDLE;
        pmc_pkg::PMC_IDLE:
          if (irq_pending)
            state_q <= pmc_pkg::PMC_NORMAL;
        pmc_pkg::PMC_STOP:
          state_q <= pmc_pkg::PMC_STOP;
        pmc_pkg::PMC_SHUTDOWN:
          state_q <= pmc_pkg::PMC_SHUTDOWN;
        default:
          state_q <= pmc_pkg::PMC_NORMAL;
      endcase
    end
  end

  //--------------------------------------------------
  // idle bit and resume bookkeeping
  //--------------------------------------------------
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
      idle_bit_q <= 1'b0;
    else if (reset_req)
      idle_bit_q <= 1'b0;
    else if (state_q == pmc_pkg::PMC_IDLE && irq_pending)
      idle_bit_q <= 1'b0;
    else if (idle_set && !stop_set && state_q == pmc_pkg::PMC_NORMAL && !req_q)
      idle_bit_q <= 1'b1;
  end

  // marks that the handler running returns to the instruction after the idle write
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
      resume_q <= 1'b0;
    else if (reset_req)
      resume_q <= 1'b0;
    else if (state_q == pmc_pkg::PMC_IDLE && irq_pending)
      resume_q <= 1'b1;
    else if (interrupt_return_instr)
      resume_q <= 1'b0;
  end

  //--------------------------------------------------
  // outputs
  //--------------------------------------------------
  // idle gates only the core; peripherals keep their clock
  assign core_halt      = (state_q != pmc_pkg::PMC_NORMAL
                           && state_q != pmc_pkg::PMC_IDLE_WAIT) || rst_q;
  assign periph_clk_en  = (state_q == pmc_pkg::PMC_NORMAL
                           || state_q == pmc_pkg::PMC_IDLE_WAIT
                           || state_q == pmc_pkg::PMC_IDLE);
  assign osc_en         = periph_clk_en;
  assign regulator_en   = (state_q != pmc_pkg::PMC_SHUTDOWN);
  assign analog_pwr_en  = regulator_en;
  assign pin_hold       = (state_q == pmc_pkg::PMC_STOP
                           || state_q == pmc_pkg::PMC_SHUTDOWN);
  assign idle_bit       = idle_bit_q;
  assign resume_pending = resume_q;
  assign system_reset   = rst_q;
  assign pc_reset       = rst_q;
  assign reset_vector   = `PMC_RESET_VECTOR;
  assign clk_sel        = `PMC_CLKSEL_LPOSC;

  //--------------------------------------------------
  // checks
  //--------------------------------------------------
  AST_IDLE_AFTER_DONE: assert property (@(posedge clk_sys) disable iff (!rstn)
    (state_q == pmc_pkg::PMC_IDLE_WAIT && !instr_done && !stop_set && !reset_req)
      |=> state_q == pmc_pkg::PMC_IDLE_WAIT)
    else $error("idle entered before instruction completed");
  AST_IDLE_PERIPH_RUN: assert property (@(posedge clk_sys) disable iff (!rstn)
    state_q == pmc_pkg::PMC_IDLE |-> periph_clk_en && core_halt)
    else $error("idle stopped peripherals");
  AST_IDLE_WAKE: assert property (@(posedge clk_sys) disable iff (!rstn)
    (state_q == pmc_pkg::PMC_IDLE && irq_pending && !reset_req)
      |=> state_q == pmc_pkg::PMC_NORMAL && !idle_bit_q)
    else $error("interrupt did not end idle");
  AST_RESUME_MARK: assert property (@(posedge clk_sys) disable iff (!rstn)
    (state_q == pmc_pkg::PMC_IDLE && irq_pending && !reset_req) |=> resume_q)
    else $error("resume not marked");
  AST_RESET_IDLE: assert property (@(posedge clk_sys) disable iff (!rstn)
    (state_q == pmc_pkg::PMC_IDLE && internal_reset) |=> rst_q && state_q == pmc_pkg::PMC_NORMAL)
    else $error("reset did not end idle");
  AST_STOP_ENTRY: assert property (@(posedge clk_sys) disable iff (!rstn)
    (state_q == pmc_pkg::PMC_NORMAL && stop_set && !regulator_off_on_stop && instr_done
     && !reset_req) |=> state_q == pmc_pkg::PMC_STOP)
    else $error("stop not entered");
  AST_STOP_CLOCKS: assert property (@(posedge clk_sys) disable iff (!rstn)
    state_q == pmc_pkg::PMC_STOP |-> !osc_en && regulator_en && pin_hold)
    else $error("stop outputs wrong");
  AST_STOP_NO_IRQ: assert property (@(posedge clk_sys) disable iff (!rstn)
    (state_q == pmc_pkg::PMC_STOP && irq_pending && !reset_req) |=> state_q == pmc_pkg::PMC_STOP)
    else $error("interrupt woke stop");
  AST_SHUTDOWN_ENTRY: assert property (@(posedge clk_sys) disable iff (!rstn)
    (state_q == pmc_pkg::PMC_NORMAL && stop_set && regulator_off_on_stop && instr_done
     && !reset_req) |=> state_q == pmc_pkg::PMC_SHUTDOWN && !regulator_en)
    else $error("shutdown not entered");
  AST_SHUTDOWN_WAKE: assert property (@(posedge clk_sys) disable iff (!rstn)
    (state_q == pmc_pkg::PMC_SHUTDOWN && !wake_reset) |=> state_q == pmc_pkg::PMC_SHUTDOWN)
    else $error("shutdown left without pin or power-on reset");
  AST_SUPPLY_HOLD: assert property (@(posedge clk_sys) disable iff (!rstn)
    supply_low |=> system_reset)
    else $error("low supply did not hold reset");
  AST_BOTH_BITS: assert property (@(posedge clk_sys) disable iff (!rstn)
    (state_q == pmc_pkg::PMC_NORMAL && idle_set && stop_set && !reset_req)
      |=> state_q != pmc_pkg::PMC_IDLE && state_q != pmc_pkg::PMC_IDLE_WAIT)
    else $error("idle taken over stop");

  //--------------------------------------------------
  // checks: entry, residency and exit of each mode
  //--------------------------------------------------
  AST_IDLE_BIT_SET: assert property (@(posedge clk_sys) disable iff (!rstn)
    (state_q == pmc_pkg::PMC_NORMAL && idle_set && !stop_set && !req_q && !reset_req)
      |=> idle_bit_q)
    else $error("idle bit not set by idle write");
  AST_IDLE_WAIT_DONE: assert property (@(posedge clk_sys) disable iff (!rstn)
    (state_q == pmc_pkg::PMC_IDLE_WAIT && instr_done && !stop_set && !reset_req)
      |=> state_q == pmc_pkg::PMC_IDLE)
    else $error("idle not entered when instruction completed");
  AST_IDLE_NO_EARLY: assert property (@(posedge clk_sys) disable iff (!rstn)
    (state_q == pmc_pkg::PMC_NORMAL && idle_set && !instr_done && !stop_set && !req_q
     && !reset_req) |=> state_q == pmc_pkg::PMC_IDLE_WAIT && !core_halt)
    else $error("core halted before instruction completed");
  AST_IDLE_WAIT_RUN: assert property (@(posedge clk_sys) disable iff (!rstn)
    (state_q == pmc_pkg::PMC_IDLE_WAIT && !system_reset) |-> !core_halt)
    else $error("core halted while instruction still running");
  AST_IDLE_KEEP: assert property (@(posedge clk_sys) disable iff (!rstn)
    (state_q == pmc_pkg::PMC_IDLE && !irq_pending && !reset_req)
      |=> state_q == pmc_pkg::PMC_IDLE && idle_bit_q)
    else $error("idle left without interrupt or reset");
  AST_IDLE_POWER_ON: assert property (@(posedge clk_sys) disable iff (!rstn)
    state_q == pmc_pkg::PMC_IDLE |-> regulator_en && analog_pwr_en && osc_en && !pin_hold)
    else $error("idle removed power or clocks");
  AST_IDLE_RELEASE: assert property (@(posedge clk_sys) disable iff (!rstn)
    (state_q == pmc_pkg::PMC_IDLE && irq_pending && !reset_req) |=> !core_halt)
    else $error("core not released by interrupt");
  AST_RESUME_HOLD: assert property (@(posedge clk_sys) disable iff (!rstn)
    (resume_q && !interrupt_return_instr && !reset_req) |=> resume_q)
    else $error("resume mark lost before interrupt return");
  AST_RESUME_CLEAR: assert property (@(posedge clk_sys) disable iff (!rstn)
    (resume_q && interrupt_return_instr && !reset_req
     && !(state_q == pmc_pkg::PMC_IDLE && irq_pending)) |=> !resume_q)
    else $error("resume mark kept after interrupt return");
  AST_RESET_VECTOR: assert property (@(posedge clk_sys) disable iff (!rstn)
    system_reset |-> pc_reset && reset_vector == `PMC_RESET_VECTOR)
    else $error("reset does not restart from address zero");
  AST_RESET_CLEARS: assert property (@(posedge clk_sys) disable iff (!rstn)
    reset_req |=> !idle_bit_q && !resume_q)
    else $error("reset left idle bookkeeping set");
  AST_STOP_PENDING: assert property (@(posedge clk_sys) disable iff (!rstn)
    (state_q == pmc_pkg::PMC_NORMAL && req_q && !sd_q && instr_done && !stop_set
     && !reset_req) |=> state_q == pmc_pkg::PMC_STOP)
    else $error("remembered stop request not taken");
  AST_STOP_POWER: assert property (@(posedge clk_sys) disable iff (!rstn)
    state_q == pmc_pkg::PMC_STOP |-> core_halt && !periph_clk_en && analog_pwr_en)
    else $error("stop clocks or regulator wrong");
  AST_STOP_PINS: assert property (@(posedge clk_sys) disable iff (!rstn)
    (state_q == pmc_pkg::PMC_STOP && !reset_req) |=> pin_hold)
    else $error("pins released during stop");
  AST_NORMAL_RUN: assert property (@(posedge clk_sys) disable iff (!rstn)
    state_q == pmc_pkg::PMC_NORMAL |-> !pin_hold && osc_en && periph_clk_en)
    else $error("normal mode clocks or pins wrong");
  AST_STOP_EXIT: assert property (@(posedge clk_sys) disable iff (!rstn)
    (state_q == pmc_pkg::PMC_STOP && reset_req)
      |=> state_q == pmc_pkg::PMC_NORMAL && system_reset)
    else $error("reset did not end stop");
  AST_SHUTDOWN_PENDING: assert property (@(posedge clk_sys) disable iff (!rstn)
    (state_q == pmc_pkg::PMC_NORMAL && req_q && sd_q && instr_done && !stop_set
     && !reset_req) |=> state_q == pmc_pkg::PMC_SHUTDOWN)
    else $error("remembered shutdown request not taken");
  AST_SHUTDOWN_POWER: assert property (@(posedge clk_sys) disable iff (!rstn)
    state_q == pmc_pkg::PMC_SHUTDOWN
      |-> !osc_en && !periph_clk_en && !analog_pwr_en && pin_hold && core_halt)
    else $error("shutdown left power or clocks on");
  AST_SHUTDOWN_INT_RST: assert property (@(posedge clk_sys) disable iff (!rstn)
    (state_q == pmc_pkg::PMC_SHUTDOWN && internal_reset && !wake_reset) |=> !system_reset)
    else $error("internal reset woke shutdown");
  AST_SHUTDOWN_IRQ: assert property (@(posedge clk_sys) disable iff (!rstn)
    (state_q == pmc_pkg::PMC_SHUTDOWN && irq_pending && !wake_reset)
      |=> state_q == pmc_pkg::PMC_SHUTDOWN && !regulator_en)
    else $error("interrupt woke shutdown");
  AST_SHUTDOWN_EXIT: assert property (@(posedge clk_sys) disable iff (!rstn)
    (state_q == pmc_pkg::PMC_SHUTDOWN && wake_reset)
      |=> state_q == pmc_pkg::PMC_NORMAL && system_reset)
    else $error("pin or power-on reset did not end shutdown");
  AST_SUPPLY_STATE: assert property (@(posedge clk_sys) disable iff (!rstn)
    supply_low |=> state_q == pmc_pkg::PMC_NORMAL && core_halt)
    else $error("low supply did not halt the core");
  AST_HALT_IN_RESET: assert property (@(posedge clk_sys) disable iff (!rstn)
    system_reset |-> core_halt)
    else $error("core running during reset");
  AST_LEAVE_RESET: assert property (@(posedge clk_sys) disable iff (!rstn)
    $fell(system_reset) |-> clk_sel == `PMC_CLKSEL_LPOSC
      && reset_vector == `PMC_RESET_VECTOR)
    else $error("reset exit clock or vector wrong");
  AST_BOTH_SHUTDOWN: assert property (@(posedge clk_sys) disable iff (!rstn)
    (state_q == pmc_pkg::PMC_NORMAL && idle_set && stop_set && regulator_off_on_stop
     && instr_done && !reset_req) |=> state_q == pmc_pkg::PMC_SHUTDOWN)
    else $error("idle and stop together did not shut down");
  AST_WAIT_STOP: assert property (@(posedge clk_sys) disable iff (!rstn)
    (state_q == pmc_pkg::PMC_IDLE_WAIT && stop_set && !reset_req)
      |=> state_q == pmc_pkg::PMC_NORMAL && req_q)
    else $error("stop during idle wait not remembered");

endmodule : pmc_power_mode_controller
`default_nettype wire

// >>> pkg/pmc_cfg.svh
// constants of the power mode controller
// assumes inclusion by bare name from design files
`ifndef PMC_CFG_SVH
`define PMC_CFG_SVH
`define PMC_RESET_VECTOR 16'h0000
`define PMC_CLKSEL_LPOSC 1'b0
`endif

// >>> pkg/pmc_pkg.sv
// types of the power mode controller
// assumes nothing of its surroundings
package pmc_pkg;
  typedef enum logic [2:0] {
    PMC_NORMAL,
    PMC_IDLE_WAIT,
    PMC_IDLE,
    PMC_STOP,
    PMC_SHUTDOWN
  } pmc_state_type;
endpackage : pmc_pkg

// >>> verif/pmc_core_model.sv
// core side of the power mode controller: mode writes and instruction completion
// assumes the bench raises a request for one cycle after a falling edge
`timescale 1ns/1ps
`default_nettype none
module pmc_core_model (
  input  wire logic clk_sys,
  input  wire logic req_idle,
  input  wire logic req_stop,
  input  wire logic slow,
  output logic      idle_set,
  output logic      stop_set,
  output logic      instr_done
);
  logic late_q;
  initial {idle_set, stop_set, instr_done, late_q} = 4'h0;
  // analog parts are left for software to switch off before a stop write
  // a slow instruction finishes one cycle after its write
  always @(negedge clk_sys)
  begin
    idle_set   <= req_idle;
    stop_set   <= req_stop;
    instr_done <= ((req_idle | req_stop) & ~slow) | late_q;
    late_q     <= (req_idle | req_stop) & slow;
  end
endmodule : pmc_core_model
`default_nettype wire

// >>> verif/test_power_mode_controller.sv
// bench for the power mode controller: mode entry, wake-up and reset hold
// assumes the core model pulses writes and completion off the falling edge
`timescale 1ns/1ps
`default_nettype none
module test_power_mode_controller;
  logic clk_sys, rstn, reg_off, irq, iret, ext_n, por_n, int_rst, low;
  logic r_i, r_s, slow, idle_set, stop_set, instr_done;
  logic core_halt, periph_clk_en, osc_en, regulator_en, analog_pwr_en, pin_hold;
  logic idle_bit, system_reset, pc_reset, clk_sel, resume_pending;
  logic [15:0] reset_vector;
  logic [5:0]  st;
  int          num_errors, total_checks, k;
  // {idle, stop, reg off, slow} then {halt, periph, osc, regulator, hold, idle bit}
  logic [9:0]  rows [7] = '{10'h23D, 10'h126, 10'h1A2, 10'h326, 10'h166, 10'h3A2, 10'h27D};
  assign st = {core_halt, periph_clk_en, osc_en, regulator_en, pin_hold, idle_bit};
  pmc_core_model core_u (.clk_sys(clk_sys), .req_idle(r_i), .req_stop(r_s), .slow(slow),
    .idle_set(idle_set), .stop_set(stop_set), .instr_done(instr_done));
  pmc_power_mode_controller dut_u (.clk_sys(clk_sys), .rstn(rstn), .idle_set(idle_set),
    .stop_set(stop_set), .regulator_off_on_stop(reg_off), .instr_done(instr_done),
    .irq_pending(irq), .interrupt_return_instr(iret), .ext_reset_n(ext_n),
    .por_reset_n(por_n), .internal_reset(int_rst), .supply_low(low),
    .core_halt(core_halt), .periph_clk_en(periph_clk_en), .osc_en(osc_en),
    .regulator_en(regulator_en), .analog_pwr_en(analog_pwr_en), .pin_hold(pin_hold),
    .idle_bit(idle_bit), .system_reset(system_reset), .pc_reset(pc_reset),
    .reset_vector(reset_vector), .clk_sel(clk_sel), .resume_pending(resume_pending));
  initial
  begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  task automatic test_done;
    $display("checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : test_done
  task automatic chk(input logic [17:0] seen, input logic [17:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("unexpected at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(negedge clk_sys);
  endtask : tick
  task automatic req(input logic [3:0] s);
    reg_off <= s[1];
    r_i     <= s[3];
    r_s     <= s[2];
    slow    <= s[0];
    tick(1);
    r_i <= 1'b0;
    r_s <= 1'b0;
    tick(4);
  endtask : req
  task automatic pin_rst;
    ext_n <= 1'b0;
    tick(2);
    chk({pc_reset, system_reset}, 2'h3);
    ext_n <= 1'b1;
    tick(3);
    chk({system_reset, st}, 7'h1C);
  endtask : pin_rst
  initial
  begin
    repeat (2000) @(posedge clk_sys);
    num_errors++;
    test_done;
  end
  initial
  begin
    {rstn, r_i, r_s, slow, reg_off, irq, iret, int_rst, low} = 9'h000;
    {ext_n, por_n} = 2'h3;
    tick(20);
    chk(system_reset, 1'b1);
    chk({idle_bit, clk_sel, reset_vector}, 18'h00000);
    rstn <= 1'b1;
    tick(3);
    chk({system_reset, st}, 7'h1C);
    for (k = 0; k < 7; k++)
    begin
      req(rows[k][9:6]);
      chk(st, rows[k][5:0]);
      chk(analog_pwr_en, rows[k][2]);
      pin_rst;
      $display("row %0d done", k);
    end
    // idle ends on an interrupt; resume flag stays up until the return
    req(4'h8);
    irq <= 1'b1;
    tick(2);
    chk({core_halt, idle_bit, resume_pending}, 3'h1);
    irq  <= 1'b0;
    iret <= 1'b1;
    tick(1);
    iret <= 1'b0;
    tick(1);
    chk({core_halt, resume_pending}, 2'h0);
    $display("idle wake done");
    // an internal reset ends idle with an ordinary reset
    req(4'h8);
    int_rst <= 1'b1;
    tick(2);
    chk({system_reset, idle_bit}, 2'h2);
    int_rst <= 1'b0;
    tick(3);
    chk({system_reset, st}, 7'h1C);
    $display("idle reset done");
    // stop ignores interrupts, an internal reset ends it
    req(4'h4);
    irq <= 1'b1;
    tick(3);
    chk(st, 6'h26);
    irq     <= 1'b0;
    int_rst <= 1'b1;
    tick(2);
    chk(system_reset, 1'b1);
    int_rst <= 1'b0;
    tick(3);
    chk({system_reset, st}, 7'h1C);
    $display("stop wake done");
    // shutdown ignores internal reset and interrupts, power-on reset ends it
    req(4'h6);
    int_rst <= 1'b1;
    irq     <= 1'b1;
    tick(3);
    chk({system_reset, st}, 7'h22);
    {int_rst, irq} <= 2'h0;
    por_n <= 1'b0;
    tick(2);
    chk(system_reset, 1'b1);
    por_n <= 1'b1;
    tick(3);
    $display("shutdown wake done");
    low <= 1'b1;
    tick(5);
    chk(system_reset, 1'b1);
    low <= 1'b0;
    tick(3);
    chk({system_reset, st}, 7'h1C);
    $display("supply hold done");
    test_done;
  end
endmodule : test_power_mode_controller
`default_nettype wire
